// *** pkg/pspc_pkg.sv ***
// Shared constants and types of the power stage protection controller.
// Assumes one core clock; all pins arrive synchronous to it.
package pspc_pkg;

   // ------------------------------------------------------------
   // Structure
   // ------------------------------------------------------------
   localparam int NUM_HB = 4;
   localparam int NUM_PAIR = 2;

   // ------------------------------------------------------------
   // Autorecovery timing in PWM input cycles
   // ------------------------------------------------------------
   localparam int AR_CYCLES = 512;
   localparam int AR_CNT_W = 10;
   localparam logic [AR_CNT_W-1:0] AR_HALF_CNT = AR_CNT_W'(AR_CYCLES / 2 - 1);
   localparam logic [AR_CNT_W-1:0] AR_FULL_CNT = AR_CNT_W'(AR_CYCLES - 1);

   // ------------------------------------------------------------
   // Register map (byte addresses)
   // ------------------------------------------------------------
   localparam int REG_AW = 8;
   localparam logic [REG_AW-1:0] REG_STATUS = 8'h00;
   localparam logic [REG_AW-1:0] REG_EVENTS = 8'h04;
   localparam logic [REG_AW-1:0] REG_CTRL = 8'h08;
   // Status fields
   localparam int STS_LATCH_LSB = 0;
   localparam int STS_HIZ_LSB = 2;
   localparam int STS_MODE_LSB = 4;
   localparam int STS_CFG_BIT = 6;
   localparam int STS_TWARN_BIT = 7;
   localparam int STS_FPIN_LSB = 8;
   localparam int STS_TPIN_BIT = 10;
   // Event fields, write one to clear
   localparam int EVT_W = 4;
   localparam int EVT_OC_BIT = 0;
   localparam int EVT_OTE_BIT = 1;
   localparam int EVT_UV_BIT = 2;
   localparam int EVT_TW_BIT = 3;
   localparam logic [EVT_W-1:0] EVT_RESET = 4'h0;
   // Control fields
   localparam int CTRL_W = 4;
   localparam int CTL_OVR_BIT = 0;
   localparam int CTL_MODE_LSB = 1;
   localparam int CTL_MUTE_BIT = 3;
   localparam logic [CTRL_W-1:0] CTRL_RESET = 4'h0;

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      PM_AUTO = 2'b00,
      PM_LATCH = 2'b01,
      PM_UNPROT = 2'b10
   } pspc_mode_t;

   // Strap code {sel_a, sel_b} that selects latching shutdown
   localparam logic [1:0] STRAP_LATCH = 2'h1;

   typedef enum logic [1:0] {
      ST_MUTE = 2'b00,
      ST_RUN = 2'b01,
      ST_TRIP = 2'b10,
      ST_RECOVER = 2'b11
   } pspc_state_t;

   typedef struct packed {
      logic oc;
      logic overtemp_error;
      logic uv;
   } pspc_err_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [REG_AW-1:0] addr;
      logic [31:0] wdata;
   } pspc_reg_req_t;

endpackage

// *** hdl/pspc_pair_ctrl.sv ***
// Protection sequencer for one pair of half-bridges sharing one reset pin.
// Assumes reset_n, pwm_pos and the error flags are synchronous to core_clk.
`timescale 1ns/1ps
`default_nettype none
module pspc_pair_ctrl (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Pair pins
   input wire logic reset_n,
   input wire logic pwm_pos,
   // Protection inputs
   input wire pspc_pkg::pspc_mode_t mode,
   input wire pspc_pkg::pspc_err_t err,
   // Status
   output logic hiz,
   output logic latched
);
   import pspc_pkg::*;

   logic reset_n_q_r;
   logic pwm_q_r;
   logic reset_fall;
   logic pwm_rise;
   logic err_now;
   logic half_hit;
   logic full_hit;
   pspc_state_t state_r;
   pspc_state_t state_nxt;
   logic latch_r;
   logic [AR_CNT_W-1:0] cnt_r;

   // --------------------------------------------------------
   // Edge detection
   // --------------------------------------------------------
   // Previous levels of reset and the positive PWM input
   always_ff @(posedge core_clk) begin
      if (rst) begin
         reset_n_q_r <= 1'b0;
         pwm_q_r <= 1'b0;
      end else begin
         reset_n_q_r <= reset_n;
         pwm_q_r <= pwm_pos;
      end
   end

   assign reset_fall = reset_n_q_r && !reset_n;
   assign pwm_rise = pwm_pos && !pwm_q_r;
   // Test mode masks every monitor
   assign err_now = (mode != PM_UNPROT) && (err.oc || err.overtemp_error || err.uv);
   assign half_hit = pwm_rise && (cnt_r == AR_HALF_CNT);
   assign full_hit = pwm_rise && (cnt_r == AR_FULL_CNT);

   // --------------------------------------------------------
   // Sequencer
   // --------------------------------------------------------
   // Any state other than RUN keeps the bridges in high impedance
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         ST_MUTE: begin
            if (latch_r || err_now) begin
               state_nxt = ST_TRIP;
            end else begin
               state_nxt = ST_RUN;
            end
         end
         ST_RUN: begin
            if (err_now) begin
               state_nxt = ST_TRIP;
            end
         end
         ST_TRIP: begin
            // Latching mode never leaves here by itself
            if (mode == PM_AUTO && half_hit) begin
               state_nxt = ST_RECOVER;
            end
         end
         ST_RECOVER: begin
            if (err_now) begin
               state_nxt = ST_TRIP;
            end else if (full_hit) begin
               state_nxt = ST_RUN;
            end
         end
      endcase
      if (!reset_n) begin
         state_nxt = ST_MUTE;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         state_r <= ST_MUTE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // --------------------------------------------------------
   // Error latch
   // --------------------------------------------------------
   // A live error beats any clear so no event is lost
   always_ff @(posedge core_clk) begin
      if (rst) begin
         latch_r <= 1'b0;
      end else if (err_now) begin
         latch_r <= 1'b1;
      end else if (reset_fall) begin
         latch_r <= 1'b0;
      end else if (state_r == ST_TRIP && state_nxt == ST_RECOVER) begin
         latch_r <= 1'b0;
      end
   end

   // --------------------------------------------------------
   // Recovery counter, one per pair, paced by PWM cycles
   // --------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (rst) begin
         cnt_r <= '0;
      end else if (state_nxt == ST_TRIP && state_r != ST_TRIP) begin
         cnt_r <= '0;
      end else if (state_r == ST_TRIP || state_r == ST_RECOVER) begin
         if (mode == PM_AUTO && pwm_rise) begin
            cnt_r <= cnt_r + 1'b1;
         end
      end else begin
         cnt_r <= '0;
      end
   end

   assign hiz = (state_r != ST_RUN);
   assign latched = latch_r;

endmodule
`default_nettype wire

// *** hdl/pspc_power_stage_ctrl.sv ***
// Top of the protection and status logic of a stereo PWM power stage.
// Assumes all pins and monitor flags are synchronous to core_clk and that
// the controller keeps its reset and PWM sequencing duties.
//
// The register addresses and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module pspc_power_stage_ctrl (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Bridge resets
   input wire logic bridge_ab_reset_n,
   input wire logic bridge_cd_reset_n,
   // PWM inputs, half-bridges A to D
   input wire logic [pspc_pkg::NUM_HB-1:0] pwm_pos_in,
   input wire logic [pspc_pkg::NUM_HB-1:0] pwm_neg_in,
   // Strap inputs
   input wire logic prot_sel_a,
   input wire logic prot_sel_b,
   input wire logic output_cfg_sel,
   // Analog monitor flags
   input wire logic [pspc_pkg::NUM_HB-1:0] oc_hs_in,
   input wire logic [pspc_pkg::NUM_HB-1:0] oc_ls_in,
   input wire logic gate_uv_in,
   input wire logic temp_warn_in,
   input wire logic temp_err_in,
   // Register port
   input wire pspc_pkg::pspc_reg_req_t reg_req,
   output logic [31:0] reg_rdata,
   // Gate drive
   output logic [pspc_pkg::NUM_HB-1:0] hs_gate_on,
   output logic [pspc_pkg::NUM_HB-1:0] ls_gate_on,
   // Open-drain fault pins, one per pair
   input wire logic [pspc_pkg::NUM_PAIR-1:0] fault_out_n_i,
   output logic [pspc_pkg::NUM_PAIR-1:0] fault_out_n_o,
   output logic [pspc_pkg::NUM_PAIR-1:0] fault_out_n_oe,
   // Open-drain temperature warning pin
   input wire logic temp_warn_n_i,
   output logic temp_warn_n_o,
   output logic temp_warn_n_oe
);
   import pspc_pkg::*;

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   logic [NUM_PAIR-1:0] pair_reset_n;
   logic [NUM_PAIR-1:0] pair_hiz;
   logic [NUM_PAIR-1:0] pair_latch;
   pspc_mode_t strap_mode_r;
   pspc_mode_t mode_eff;
   logic cfg_bad_r;
   logic [CTRL_W-1:0] ctrl_r;
   logic [EVT_W-1:0] evt_r;
   logic [EVT_W-1:0] evt_set;
   logic [EVT_W-1:0] evt_clr;
   logic any_oc;
   logic soft_mute;
   logic [NUM_HB-1:0] hs_gate_r;
   logic [NUM_HB-1:0] ls_gate_r;
   logic [NUM_PAIR-1:0] fault_oe_r;
   logic [NUM_PAIR-1:0] fault_lvl_r;
   logic twarn_oe_r;
   logic twarn_lvl_r;
   logic [31:0] rdata_r;
   logic [31:0] status_word;
   logic [31:0] rdata_nxt;

   assign pair_reset_n = {bridge_cd_reset_n, bridge_ab_reset_n};

   // ------------------------------------------------------------
   // Protection mode selection
   // ------------------------------------------------------------
   // Straps are static board ties, so sampling them every cycle
   // costs nothing and avoids a stale copy after a board rework.
   always_ff @(posedge core_clk) begin
      if (rst) begin
         strap_mode_r <= PM_LATCH;
         cfg_bad_r <= 1'b0;
      end else begin
         if ({prot_sel_a, prot_sel_b} == STRAP_LATCH) begin
            strap_mode_r <= PM_LATCH;
         end else begin
            strap_mode_r <= PM_LATCH;
         end
         cfg_bad_r <= output_cfg_sel;
      end
   end

   // The straps only reach latching mode, so software may pick the
   // other modes; an unused override code is never weaker than latching.
   always_comb begin
      mode_eff = strap_mode_r;
      if (ctrl_r[CTL_OVR_BIT]) begin
         unique case (ctrl_r[CTL_MODE_LSB +: 2])
            2'h0: mode_eff = PM_AUTO;
            2'h1: mode_eff = PM_LATCH;
            2'h2: mode_eff = PM_UNPROT;
            default: mode_eff = PM_LATCH;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Pair sequencers
   // ------------------------------------------------------------
   // Undervoltage and overtemperature error flags are common to both pairs;
   // overcurrent is local to the two half-bridges of each pair.
   genvar gp;
   generate
      for (gp = 0; gp < NUM_PAIR; gp++) begin : g_pair
         pspc_err_t pair_err;
         always_comb begin
            pair_err.oc = |(oc_hs_in[2*gp +: 2] | oc_ls_in[2*gp +: 2]);
            pair_err.overtemp_error = temp_err_in;
            pair_err.uv = gate_uv_in;
         end
         pspc_pair_ctrl u_pair (
            .core_clk (core_clk),
            .rst (rst),
            .reset_n (pair_reset_n[gp]),
            .pwm_pos (pwm_pos_in[2*gp]),
            .mode (mode_eff),
            .err (pair_err),
            .hiz (pair_hiz[gp]),
            .latched (pair_latch[gp])
         );
      end
   endgenerate

   // ------------------------------------------------------------
   // Gate drive
   // ------------------------------------------------------------
   assign soft_mute = ctrl_r[CTL_MUTE_BIT] | cfg_bad_r;

   // A high-impedance bridge has both transistors off. A reserved
   // output configuration is held quiet rather than guessed at.
   genvar gh;
   generate
      for (gh = 0; gh < NUM_HB; gh++) begin : g_hb
         always_ff @(posedge core_clk) begin
            if (rst) begin
               hs_gate_r[gh] <= 1'b0;
               ls_gate_r[gh] <= 1'b0;
            end else if (pair_hiz[gh/2] || soft_mute) begin
               hs_gate_r[gh] <= 1'b0;
               ls_gate_r[gh] <= 1'b0;
            end else begin
               hs_gate_r[gh] <= pwm_pos_in[gh];
               ls_gate_r[gh] <= pwm_neg_in[gh] & ~pwm_pos_in[gh];
            end
         end
      end
   endgenerate

   assign hs_gate_on = hs_gate_r;
   assign ls_gate_on = ls_gate_r;

   // ------------------------------------------------------------
   // Status pins
   // ------------------------------------------------------------
   // Fault pin pulls low only with reset high and the latch set; the
   // pull-up gives the high level, so the driven level is always low.
   always_ff @(posedge core_clk) begin
      if (rst) begin
         fault_oe_r <= '0;
         fault_lvl_r <= '0;
      end else begin
         fault_oe_r <= pair_latch & pair_reset_n;
         fault_lvl_r <= '0;
      end
   end

   // Warning pin follows the 125 C comparator directly
   always_ff @(posedge core_clk) begin
      if (rst) begin
         twarn_oe_r <= 1'b0;
         twarn_lvl_r <= 1'b0;
      end else begin
         twarn_oe_r <= temp_warn_in;
         twarn_lvl_r <= 1'b0;
      end
   end

   assign fault_out_n_o = fault_lvl_r;
   assign fault_out_n_oe = fault_oe_r;
   assign temp_warn_n_o = twarn_lvl_r;
   assign temp_warn_n_oe = twarn_oe_r;

   // ------------------------------------------------------------
   // Event capture
   // ------------------------------------------------------------
   // Sticky records of every monitor, kept even in test mode so that
   // software can see what the bridges survived.
   assign any_oc = |(oc_hs_in | oc_ls_in);

   always_comb begin
      evt_set = '0;
      evt_set[EVT_OC_BIT] = any_oc;
      evt_set[EVT_OTE_BIT] = temp_err_in;
      evt_set[EVT_UV_BIT] = gate_uv_in;
      evt_set[EVT_TW_BIT] = temp_warn_in;
   end

   assign evt_clr = (reg_req.wr && reg_req.addr == REG_EVENTS) ?
                    reg_req.wdata[EVT_W-1:0] : '0;

   // Set wins over a clear in the same cycle
   always_ff @(posedge core_clk) begin
      if (rst) begin
         evt_r <= EVT_RESET;
      end else begin
         evt_r <= (evt_r & ~evt_clr) | evt_set;
      end
   end

   // ------------------------------------------------------------
   // Control register
   // ------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (rst) begin
         ctrl_r <= CTRL_RESET;
      end else if (reg_req.wr && reg_req.addr == REG_CTRL) begin
         ctrl_r <= reg_req.wdata[CTRL_W-1:0];
      end
   end

   // ------------------------------------------------------------
   // Read path
   // ------------------------------------------------------------
   always_comb begin
      status_word = '0;
      status_word[STS_LATCH_LSB +: NUM_PAIR] = pair_latch;
      status_word[STS_HIZ_LSB +: NUM_PAIR] = pair_hiz;
      status_word[STS_MODE_LSB +: 2] = mode_eff;
      status_word[STS_CFG_BIT] = cfg_bad_r;
      status_word[STS_TWARN_BIT] = temp_warn_in;
      status_word[STS_FPIN_LSB +: NUM_PAIR] = fault_out_n_i;
      status_word[STS_TPIN_BIT] = temp_warn_n_i;
   end

   // Unmapped addresses read as zero
   always_comb begin
      rdata_nxt = '0;
      unique case (reg_req.addr)
         REG_STATUS: rdata_nxt = status_word;
         REG_EVENTS: rdata_nxt[EVT_W-1:0] = evt_r;
         REG_CTRL: rdata_nxt[CTRL_W-1:0] = ctrl_r;
         default: rdata_nxt = '0;
      endcase
   end

   // Data stand only in the cycle after the read strobe
   always_ff @(posedge core_clk) begin
      if (rst) begin
         rdata_r <= '0;
      end else if (reg_req.rd) begin
         rdata_r <= rdata_nxt;
      end else begin
         rdata_r <= '0;
      end
   end

   assign reg_rdata = rdata_r;

endmodule
`default_nettype wire

// *** sim/pspc_chk.sv ***
// Checker for the pins of the power stage protection controller top.
// Assumes one core clock with synchronous rst; attached by the bind below.
`timescale 1ns/1ps
`default_nettype none
module pspc_chk (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Inputs of the design
   input wire logic bridge_ab_reset_n,
   input wire logic [3:0] pwm_pos_in,
   input wire logic [3:0] pwm_neg_in,
   input wire logic output_cfg_sel,
   input wire logic [3:0] oc_hs_in,
   input wire logic [3:0] oc_ls_in,
   input wire logic gate_uv_in,
   input wire logic temp_warn_in,
   input wire logic temp_err_in,
   input wire pspc_pkg::pspc_reg_req_t reg_req,
   // Outputs of the design
   input wire logic [31:0] reg_rdata,
   input wire logic [3:0] hs_gate_on,
   input wire logic [3:0] ls_gate_on,
   input wire logic [1:0] fault_out_n_o,
   input wire logic [1:0] fault_out_n_oe,
   input wire logic temp_warn_n_o,
   input wire logic temp_warn_n_oe
);
   import pspc_pkg::*;
   logic [CTRL_W-1:0] ctl_r;
   logic unprot;
   logic ab_err;
   logic ab_off;
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   // Shadow of the control word, so error checks skip the unprotected mode
   always_ff @(posedge core_clk) begin
      if (rst) begin
         ctl_r <= CTRL_RESET;
      end else if (reg_req.wr && reg_req.addr == REG_CTRL) begin
         ctl_r <= reg_req.wdata[CTRL_W-1:0];
      end
   end
   // Errors that reach pair AB; supply and heat are shared
   assign unprot = ctl_r[CTL_OVR_BIT] && ctl_r[CTL_MODE_LSB+:2] == PM_UNPROT;
   assign ab_err = |{oc_hs_in[1:0], oc_ls_in[1:0], gate_uv_in, temp_err_in};
   assign ab_off = hs_gate_on[1:0] == 2'h0 && ls_gate_on[1:0] == 2'h0;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   rdata_idle_a: assert property (!$past(reg_req.rd) |-> reg_rdata == 32'h0)
      else $error("read data outside the answer cycle");
   mute_gates_a: assert property (!bridge_ab_reset_n ##1 !bridge_ab_reset_n |=> ab_off)
      else $error("pair switches while reset is low");
   fault_release_a: assert property (!bridge_ab_reset_n |=> !fault_out_n_oe[0])
      else $error("fault pin pulled while reset is low");
   err_hiz_a: assert property (ab_err && !unprot |-> ##2 ab_off)
      else $error("error did not stop switching");
   err_fault_a: assert property (ab_err && !unprot && bridge_ab_reset_n
      ##1 bridge_ab_reset_n |=> fault_out_n_oe[0])
      else $error("error not shown on fault pin");
   unprot_quiet_a: assert property (unprot && $past(unprot) && bridge_ab_reset_n
      && $past(bridge_ab_reset_n) && !$past(fault_out_n_oe[0]) |-> !fault_out_n_oe[0])
      else $error("fault raised in unprotected mode");
   warn_pin_a: assert property ($changed(temp_warn_in)
      |=> temp_warn_n_oe == $past(temp_warn_in))
      else $error("warning pin does not follow the monitor");
   od_low_a: assert property (fault_out_n_o == 2'h0 && !temp_warn_n_o)
      else $error("open-drain pin driven high");
   gate_src_a: assert property ((hs_gate_on & ~$past(pwm_pos_in)) == 4'h0
      && (ls_gate_on & (~$past(pwm_neg_in) | $past(pwm_pos_in))) == 4'h0)
      else $error("gate on without its PWM request");
   cfg_off_a: assert property (output_cfg_sel [*3] |-> {hs_gate_on, ls_gate_on} == 8'h0)
      else $error("gates on with reserved output setting");
   soft_mute_a: assert property (ctl_r[CTL_MUTE_BIT] |=> {hs_gate_on, ls_gate_on} == 8'h0)
      else $error("gates on under soft mute");
endmodule

bind pspc_power_stage_ctrl pspc_chk u_chk (.core_clk, .rst, .bridge_ab_reset_n, .pwm_pos_in,
   .pwm_neg_in, .output_cfg_sel, .oc_hs_in, .oc_ls_in, .gate_uv_in, .temp_warn_in,
   .temp_err_in, .reg_req, .reg_rdata, .hs_gate_on, .ls_gate_on, .fault_out_n_o,
   .fault_out_n_oe, .temp_warn_n_o, .temp_warn_n_oe);
`default_nettype wire

// *** sim/pspc_ctrl_model.sv ***
// Model of the modulator that drives the pair resets and PWM inputs.
// Assumes the bench says when the gate supply is up and which pair to mute.
`timescale 1ns/1ps
`default_nettype none
module pspc_ctrl_model #(
   parameter int HOLD_CYC = 10000, // Cycles from supply up to reset release
   parameter int PWM_PER = 26 // 384.6 kHz at 10 MHz
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Bench commands
   input wire logic pwr_on,
   input wire logic [1:0] rst_req_n,
   input wire logic [4:0] duty,
   // Pins towards the power stage
   output logic bridge_ab_reset_n,
   output logic bridge_cd_reset_n,
   output logic [3:0] pwm_pos_in,
   output logic [3:0] pwm_neg_in
);
   logic [13:0] hold_r;
   logic [4:0] ph_r;
   logic run_r;
   logic p;
   logic up;

   // ------------------------------------------------------------
   // Sequencing
   // ------------------------------------------------------------
   // PWM stops one cycle after pwr_on and both resets are all low
   always_ff @(posedge core_clk) begin
      if (rst) begin
         run_r <= 1'h0;
         hold_r <= 14'h0;
         ph_r <= 5'h0;
      end else begin
         run_r <= pwr_on || bridge_ab_reset_n || bridge_cd_reset_n;
         hold_r <= (pwr_on && run_r) ? hold_r + 14'(hold_r < 14'(HOLD_CYC)) : 14'h0;
         ph_r <= (run_r && ph_r < 5'(PWM_PER - 1)) ? ph_r + 5'h1 : 5'h0;
      end
   end
   // Release only once settled and streaming
   assign up = pwr_on && run_r && hold_r == 14'(HOLD_CYC);
   always_ff @(posedge core_clk) begin
      bridge_ab_reset_n <= !rst && up && rst_req_n[0];
      bridge_cd_reset_n <= !rst && up && rst_req_n[1];
   end
   // Duty stays inside the period, so no input stays high; idle lines pulled down
   assign p = ph_r < duty;
   assign pwm_pos_in = run_r ? {~p, p, ~p, p} : 4'h0;
   assign pwm_neg_in = run_r ? {p, ~p, p, ~p} : 4'h0;
endmodule
`default_nettype wire

// *** sim/pspc_power_stage_ctrl_tb_top.sv ***
// Self-checking bench of the power stage protection controller.
// Assumes the modulator model and the checker bound to the design.
`timescale 1ns/1ps
`default_nettype none
module pspc_power_stage_ctrl_tb_top;
   import pspc_pkg::*;
   // Stimulus
   logic core_clk = 1'h0, rst = 1'h1, pwr_on = 1'h0, output_cfg_sel = 1'h0;
   logic temp_warn_in = 1'h0, rd_d = 1'h0, bridge_ab_reset_n, bridge_cd_reset_n;
   logic [1:0] rst_req_n = 2'h3, strap = 2'h1, pr, fault_out_n_o, fault_out_n_oe;
   logic [4:0] duty = 5'hD;
   logic [9:0] fl = 10'h0;
   pspc_reg_req_t reg_req = '0;
   // Observed pins and bookkeeping
   logic [3:0] pwm_pos_in, pwm_neg_in, hs_gate_on, ls_gate_on;
   logic [31:0] reg_rdata, e, m;
   logic temp_warn_n_o, temp_warn_n_oe;
   logic [63:0] exp_q[$];
   int err_total = 0, tests_run = 0, i, b;

   // ------------------------------------------------------------
   // Parts
   // ------------------------------------------------------------
   // Pull-ups give the level of released open-drain pins
   pspc_power_stage_ctrl DUT (.core_clk, .rst, .bridge_ab_reset_n, .bridge_cd_reset_n,
      .pwm_pos_in, .pwm_neg_in, .prot_sel_a(strap[1]), .prot_sel_b(strap[0]),
      .output_cfg_sel, .oc_hs_in(fl[3:0]), .oc_ls_in(fl[7:4]), .gate_uv_in(fl[8]),
      .temp_warn_in, .temp_err_in(fl[9]), .reg_req, .reg_rdata, .hs_gate_on, .ls_gate_on,
      .fault_out_n_i(~fault_out_n_oe), .fault_out_n_o, .fault_out_n_oe,
      .temp_warn_n_i(~temp_warn_n_oe), .temp_warn_n_o, .temp_warn_n_oe);
   // Full 1 ms settle time keeps bootstrap charging legal before release
   pspc_ctrl_model #(.HOLD_CYC(10000), .PWM_PER(26)) u_mdl (.core_clk, .rst, .pwr_on,
      .rst_req_n, .duty, .bridge_ab_reset_n, .bridge_cd_reset_n, .pwm_pos_in, .pwm_neg_in);

   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   function automatic logic [31:0] st(input logic [1:0] lat, hz, fp, input logic wp);
      return {21'h0, wp, fp, 4'h0, hz, lat};
   endfunction
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   // One strobe cycle; a read notes its masked expectation
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, m);
      @(posedge core_clk);
      reg_req <= '{wr: w, rd: !w, addr: a, wdata: d};
      if (!w) exp_q.push_back({m, d & m});
      @(posedge core_clk);
      reg_req <= '0;
   endtask
   task automatic stat(input logic [1:0] lat, hz, fp, input logic wp);
      bus(1'h0, REG_STATUS, st(lat, hz, fp, wp), 32'h70F);
   endtask
   // Counts rising edges of PWM A as the design samples them
   task automatic edges(input int n);
      repeat (n) begin
         do cyc(1); while (pwm_pos_in[0] !== 1'h0);
         do cyc(1); while (pwm_pos_in[0] !== 1'h1);
      end
   endtask
   task automatic pulse(input int n);
      @(posedge core_clk);
      fl <= 10'h1 << n;
      @(posedge core_clk);
      fl <= 10'h0;
   endtask
   task automatic stop_test();
      $display("Checks %0d, mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // ------------------------------------------------------------
   // Processes
   // ------------------------------------------------------------
   initial begin
      forever #50 core_clk = ~core_clk;
   end
   // Read answers land in the cycle after the strobe
   always @(posedge core_clk) rd_d <= reg_req.rd;
   always @(negedge core_clk) begin
      if (rd_d === 1'h1) begin
         {m, e} = exp_q.pop_front();
         tests_run++;
         if ((reg_rdata & m) !== e) begin
            err_total++;
            $display("BAD reg_rdata expected %h seen %h", e, reg_rdata & m);
         end
      end
   end
   // Whole run is near 3.7 ms
   initial begin
      #8000000;
      err_total++;
      stop_test();
   end
   initial begin
      void'($urandom(32'h1B967F3D));
      cyc(4);
      rst <= 1'h0;
      // Reset values, unmapped place, all strap codes with pairs in reset
      bus(1'h0, REG_CTRL, 32'(CTRL_RESET), 32'hF);
      bus(1'h0, REG_EVENTS, 32'(EVT_RESET), 32'hF);
      bus(1'h1, 8'h0C, 32'hFFFFFFFF, 32'h0);
      bus(1'h0, 8'h0C, 32'h0, 32'hFFFFFFFF);
      for (i = 0; i < 4; i++) begin
         strap <= 2'(i);
         cyc(3);
         bus(1'h0, REG_STATUS, st(2'h0, 2'h3, 2'h3, 1'h1) | 32'h10, 32'h73F);
      end
      strap <= 2'h1;
      temp_warn_in <= 1'h1;
      cyc(3);
      bus(1'h0, REG_STATUS, 32'h380, 32'h780);
      temp_warn_in <= 1'h0;
      duty <= 5'(1 + $urandom % 25);
      pwr_on <= 1'h1;
      while (bridge_ab_reset_n !== 1'h1) cyc(1);
      cyc(4);
      stat(2'h0, 2'h0, 2'h3, 1'h1);
      // Latching: each cause, then a reset toggle
      for (i = 0; i < 6; i++) begin
         b = (i > 3) ? i + 4 : (i % 2) * 4 + (i / 2) * 2 + $urandom % 2;
         pr = (i > 3) ? 2'h3 : (i < 2) ? 2'h1 : 2'h2;
         temp_warn_in <= (i == 5);
         pulse(b);
         cyc(4);
         stat(pr, pr, ~pr, i != 5);
         if (i == 0) begin
            edges(520);
            stat(pr, pr, ~pr, 1'h1);
         end
         temp_warn_in <= 1'h0;
         rst_req_n <= 2'h0;
         cyc(3);
         stat(2'h0, 2'h3, 2'h3, 1'h1);
         rst_req_n <= 2'h3;
         cyc(6);
         stat(2'h0, 2'h0, 2'h3, 1'h1);
      end
      // Autorecovery around both counter boundaries
      bus(1'h1, REG_CTRL, 32'h1, 32'h0);
      bus(1'h0, REG_STATUS, 32'(PM_AUTO) << STS_MODE_LSB, 32'h30);
      edges(1);
      pulse(1);
      edges(255);
      stat(2'h1, 2'h1, 2'h2, 1'h1);
      edges(1);
      cyc(3);
      stat(2'h0, 2'h1, 2'h3, 1'h1);
      edges(255);
      stat(2'h0, 2'h1, 2'h3, 1'h1);
      edges(1);
      cyc(3);
      stat(2'h0, 2'h0, 2'h3, 1'h1);
      // Unprotected: error ignored, still recorded and cleared by writing one
      bus(1'h1, REG_CTRL, 32'h5, 32'h0);
      bus(1'h1, REG_EVENTS, 32'hF, 32'h0);
      bus(1'h0, REG_STATUS, 32'(PM_UNPROT) << STS_MODE_LSB, 32'h30);
      pulse(0);
      cyc(4);
      stat(2'h0, 2'h0, 2'h3, 1'h1);
      bus(1'h0, REG_EVENTS, 32'h1 << EVT_OC_BIT, 32'hF);
      bus(1'h1, REG_EVENTS, 32'h1 << EVT_OC_BIT, 32'h0);
      bus(1'h0, REG_EVENTS, 32'h0, 32'hF);
      // Soft mute with the unused override code, then the reserved output setting
      bus(1'h1, REG_CTRL, 32'hF, 32'h0);
      edges(1);
      output_cfg_sel <= 1'h1;
      edges(2);
      bus(1'h0, REG_STATUS, 32'h50, 32'h70);
      output_cfg_sel <= 1'h0;
      pwr_on <= 1'h0;
      cyc(4);
      stat(2'h0, 2'h3, 2'h3, 1'h1);
      // Let the last answer reach the checking process
      cyc(2);
      stop_test();
   end
endmodule
`default_nettype wire
